// ==== include/mss_pkg.sv ====
package mss_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned S_MS          = 1000;
  localparam logic [9:0]  S_MS_LAST     = 10'(S_MS - 1);
  localparam logic [13:0] WAIT_MAX      = 14'h2710;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_CYCLE,
    MODE_SWITCH,
    MODE_SEQ
  } mss_mode_t;

  localparam logic [3:0] SRC_MULTI = 4'h2;

  typedef struct packed {
    logic [13:0] rsv_hi;
    logic        unit_s;
    logic        restart;
    logic [2:0]  rsv_mid;
    logic [4:0]  end_seg;
    logic [1:0]  rsv_lo;
    mss_mode_t   mode;
    logic [3:0]  src;
  } mss_ctrl_t;

  localparam logic [31:0] CTRL_MASK  = 32'h0003_1F3F;
  localparam mss_ctrl_t   CTRL_RESET = '{mode: MODE_CYCLE, end_seg: 5'h01, default: '0};

  // Register map, byte addresses in the low 12 address bits
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SPEED  = 12'h008;
  localparam logic [11:0] ADDR_POS    = 12'h00C;
  localparam logic [3:0]  SEG_PAGE    = 4'h1;

  // Word order inside one segment's four-word block
  localparam logic [1:0] PAR_DISP  = 2'h0;
  localparam logic [1:0] PAR_SPEED = 2'h1;
  localparam logic [1:0] PAR_RAMP  = 2'h2;
  localparam logic [1:0] PAR_WAIT  = 2'h3;
  localparam logic [2:0] PAR_DONE  = 3'h4;
  localparam logic [4:0] DIV_LAST  = 5'h0F;

  localparam int unsigned MEM_AW = 6;
  localparam int unsigned MEM_DW = 32;
endpackage

// ==== include/mss_mem_if.sv ====
`timescale 1ns/1ps
interface mss_mem_if;
  logic                        we;
  logic [mss_pkg::MEM_AW-1:0]  waddr;
  logic [mss_pkg::MEM_DW-1:0]  wdata;
  logic [mss_pkg::MEM_AW-1:0]  raddr;
  logic [mss_pkg::MEM_DW-1:0]  rdata;
  modport mem  (input we, waddr, wdata, raddr, output rdata);
  modport user (output we, waddr, wdata, raddr, input rdata);
endinterface

// ==== rtl/mss_seg_mem.sv ====
`timescale 1ns/1ps
module mss_seg_mem (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  mss_mem_if.mem    mif
);
  typedef struct packed {
    logic [(1 << mss_pkg::MEM_AW)-1:0][mss_pkg::MEM_DW-1:0] mem;
    logic [mss_pkg::MEM_DW-1:0]                               rd;
  } mss_mem_st_t;

  mss_mem_st_t s_ff;
  mss_mem_st_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    // Read sees the old word on a same-cycle write; the next load picks up the new one
    nxt_s.rd = s_ff.mem[mif.raddr];
    if (mif.we)
    begin
      nxt_s.mem[mif.waddr] = mif.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign mif.rdata = s_ff.rd;
endmodule

// ==== rtl/mss_sync.sv ====
`timescale 1ns/1ps
module mss_sync #(
  parameter int unsigned W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } mss_sync_st_t;

  mss_sync_st_t s_ff;
  mss_sync_st_t nxt_s;

  always_comb
  begin
    nxt_s    = s_ff;
    nxt_s.s1 = d_i;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    // A change counts only once two stages agree
    if (s_ff.s2 == s_ff.s3)
      nxt_s.q = s_ff.s3;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign q_o = s_ff.q;
endmodule

// ==== rtl/mss_sequencer.sv ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module mss_sequencer #(
  parameter int unsigned MS_CYCLES = mss_pkg::MS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        segment_trigger_input_i,
  input  wire logic        segment_select_bit0_i,
  input  wire logic        segment_select_bit1_i,
  input  wire logic        segment_select_bit2_i,
  input  wire logic        segment_select_bit3_i,
  output logic      [31:0] ref_speed_o,
  output logic      [31:0] ref_pos_o,
  output logic             seg_active_o,
  output logic      [3:0]  seg_index_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_DIV,
    ST_RUN,
    ST_WAIT,
    ST_DONE
  } mss_state_t;

  typedef struct packed {
    mss_state_t         st;
    mss_pkg::mss_ctrl_t ctrl;
    logic [3:0]         seg;
    logic [2:0]         p;
    logic               mine;
    logic               dir;
    logic [31:0]        rem;
    logic [15:0]        tgt;
    logic [15:0]        ramp;
    logic [15:0]        step;
    logic [15:0]        spd;
    logic [13:0]        wait_v;
    logic [13:0]        wcnt;
    logic [16:0]        drem;
    logic [4:0]         dcnt;
    logic [31:0]        brake;
    logic [31:0]        pos;
    logic [31:0]        vout;
    logic [9:0]         scnt;
    logic [15:0]        mscnt;
    logic               tick;
    logic               intr;
    logic               trig_q;
  } mss_st_t;

  mss_st_t    s_ff;
  mss_st_t    nxt_s;
  logic [4:0] in_s;
  logic       trig_s;
  logic [3:0] sel_s;
  logic [11:0] addr;
  logic       seg_area;
  logic       steal;
  logic       wr_acc;
  logic       last_seg;
  logic       lvl_mode;
  logic       active;

  mss_mem_if mif ();

  mss_seg_mem u_mem (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .mif      (mif)
  );

  mss_sync #(.W(5)) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({segment_select_bit3_i, segment_select_bit2_i, segment_select_bit1_i,
                segment_select_bit0_i, segment_trigger_input_i}),
    .q_o      (in_s)
  );

  function automatic logic [3:0] f_end_idx(input logic [4:0] e);
    if (e == 5'h00)
      return 4'h0;
    else if (e > 5'h10)
      return 4'hF;
    else
      return 4'(e - 5'h01);
  endfunction

  function automatic logic [31:0] f_min32(input logic [31:0] a, input logic [31:0] b);
    return (a < b) ? a : b;
  endfunction

  assign trig_s   = in_s[0];
  assign sel_s    = in_s[4:1];
  assign addr     = paddr[11:0];
  assign seg_area = (addr[11:8] == mss_pkg::SEG_PAGE);
  assign wr_acc   = psel && penable && pwrite;
  // Bus reads of segment words steal the memory read port for one cycle; loading stalls then
  assign steal    = psel && !penable && !pwrite && seg_area;
  assign last_seg = (s_ff.seg == f_end_idx(s_ff.ctrl.end_seg));
  assign lvl_mode = (s_ff.ctrl.mode != mss_pkg::MODE_SWITCH);
  assign active   = (s_ff.st == ST_LOAD) || (s_ff.st == ST_DIV) || (s_ff.st == ST_RUN) || (s_ff.st == ST_WAIT);

  // Segment words writable at any time, taken at the next segment load
  assign mif.we    = wr_acc && seg_area;
  assign mif.waddr = addr[7:2];
  assign mif.wdata = pwdata;
  assign mif.raddr = steal ? addr[7:2] : {s_ff.seg, s_ff.p[1:0]};

  always_comb
  begin
    logic [16:0] r;
    logic [15:0] stp;
    logic [15:0] nspd;
    logic [31:0] mv;
    logic        fin;
    r    = '0;
    stp  = '0;
    nspd = '0;
    mv   = '0;
    fin  = 1'b0;
    nxt_s        = s_ff;
    nxt_s.trig_q = trig_s;
    nxt_s.mine   = (s_ff.st == ST_LOAD) && !steal;
    nxt_s.tick   = 1'b0;
    if (s_ff.mscnt == 16'(MS_CYCLES - 1))
    begin
      nxt_s.mscnt = '0;
      nxt_s.tick  = 1'b1;
    end
    else
      nxt_s.mscnt = s_ff.mscnt + 16'h0001;
    if (wr_acc && addr == mss_pkg::ADDR_CTRL)
      nxt_s.ctrl = mss_pkg::mss_ctrl_t'(pwdata & mss_pkg::CTRL_MASK);

    if (s_ff.ctrl.src != mss_pkg::SRC_MULTI)
    begin
      nxt_s.st    = ST_IDLE;
      nxt_s.spd   = '0;
      nxt_s.brake = '0;
      nxt_s.intr  = 1'b0;
    end
    else if (lvl_mode && !trig_s && active)
    begin
      // No deceleration ramp on enable loss
      nxt_s.st    = ST_IDLE;
      nxt_s.spd   = '0;
      nxt_s.brake = '0;
      nxt_s.intr  = 1'b1;
    end
    else
    begin
      unique case (s_ff.st)
        ST_IDLE:
        begin
          nxt_s.p = '0;
          if (!lvl_mode && trig_s && !s_ff.trig_q)
          begin
            nxt_s.seg = sel_s;
            nxt_s.st  = ST_LOAD;
          end
          else if (lvl_mode && trig_s)
          begin
            nxt_s.intr = 1'b0;
            nxt_s.st   = ST_LOAD;
            nxt_s.seg  = '0;
            if (s_ff.intr && !s_ff.ctrl.restart && !last_seg)
              nxt_s.seg = s_ff.seg + 4'h1;
            else if (s_ff.intr && !s_ff.ctrl.restart && s_ff.ctrl.mode != mss_pkg::MODE_CYCLE)
              nxt_s.st = ST_DONE;
          end
        end
        ST_LOAD:
        begin
          if (s_ff.mine && s_ff.p != 3'h0)
          begin
            unique case (2'(s_ff.p - 3'h1))
              mss_pkg::PAR_DISP:
              begin
                nxt_s.dir = mif.rdata[31];
                nxt_s.rem = mif.rdata[31] ? 32'(-mif.rdata) : mif.rdata;
              end
              mss_pkg::PAR_SPEED: nxt_s.tgt = mif.rdata[15:0];
              mss_pkg::PAR_RAMP:  nxt_s.ramp = mif.rdata[15:0];
              mss_pkg::PAR_WAIT:
                nxt_s.wait_v = (mif.rdata > 32'(mss_pkg::WAIT_MAX)) ? mss_pkg::WAIT_MAX : mif.rdata[13:0];
            endcase
          end
          if (s_ff.p == mss_pkg::PAR_DONE)
          begin
            nxt_s.st   = ST_DIV;
            nxt_s.dcnt = '0;
            nxt_s.drem = '0;
            nxt_s.step = s_ff.tgt;
          end
          else if (!steal)
            nxt_s.p = s_ff.p + 3'h1;
        end
        ST_DIV:
        begin
          // Speed step per millisecond = plateau / ramp time
          r = {s_ff.drem[15:0], s_ff.step[15]};
          if (r >= {1'b0, s_ff.ramp})
          begin
            nxt_s.drem = r - {1'b0, s_ff.ramp};
            nxt_s.step = {s_ff.step[14:0], 1'b1};
          end
          else
          begin
            nxt_s.drem = r;
            nxt_s.step = {s_ff.step[14:0], 1'b0};
          end
          nxt_s.dcnt = s_ff.dcnt + 5'h01;
          if (s_ff.dcnt == mss_pkg::DIV_LAST)
            nxt_s.st = ST_RUN;
        end
        ST_RUN:
        begin
          stp = (s_ff.step == 16'h0000) ? 16'h0001 : s_ff.step;
          if (s_ff.rem == 32'h0000_0000 || s_ff.tgt == 16'h0000)
            fin = 1'b1;
          else if (s_ff.tick)
          begin
            // Braking distance mirrors the distance covered while ramping up
            if (!(s_ff.ctrl.mode == mss_pkg::MODE_SEQ && !last_seg) && s_ff.rem <= s_ff.brake)
              nspd = (s_ff.spd <= stp) ? 16'h0001 : s_ff.spd - stp;
            else if (s_ff.spd < s_ff.tgt)
            begin
              nspd = (17'(s_ff.spd) + 17'(stp) >= 17'(s_ff.tgt)) ? s_ff.tgt : s_ff.spd + stp;
              nxt_s.brake = s_ff.brake + 32'(nspd);
            end
            else if (s_ff.spd > s_ff.tgt)
              nspd = (s_ff.spd - s_ff.tgt <= stp) ? s_ff.tgt : s_ff.spd - stp;
            else
              nspd = s_ff.spd;
            mv        = f_min32(32'(nspd), s_ff.rem);
            nxt_s.spd = nspd;
            nxt_s.pos = s_ff.dir ? s_ff.pos - mv : s_ff.pos + mv;
            nxt_s.rem = s_ff.rem - mv;
            fin       = (s_ff.rem == mv);
          end
          if (fin)
          begin
            nxt_s.p = '0;
            if (s_ff.ctrl.mode == mss_pkg::MODE_SEQ && !last_seg)
            begin
              // Speed and braking distance carry into the next segment
              nxt_s.seg = s_ff.seg + 4'h1;
              nxt_s.st  = ST_LOAD;
            end
            else
            begin
              nxt_s.spd   = '0;
              nxt_s.brake = '0;
              if (!lvl_mode)
                nxt_s.st = ST_IDLE;
              else if (last_seg && s_ff.ctrl.mode != mss_pkg::MODE_CYCLE)
                nxt_s.st = ST_DONE;
              else
              begin
                nxt_s.st   = ST_WAIT;
                nxt_s.wcnt = s_ff.wait_v;
                nxt_s.scnt = '0;
              end
            end
          end
        end
        ST_WAIT:
        begin
          if (s_ff.wcnt == 14'h0000)
          begin
            nxt_s.st  = ST_LOAD;
            nxt_s.p   = '0;
            nxt_s.seg = last_seg ? 4'h0 : s_ff.seg + 4'h1;
          end
          else if (s_ff.tick)
          begin
            if (!s_ff.ctrl.unit_s)
              nxt_s.wcnt = s_ff.wcnt - 14'h0001;
            else if (s_ff.scnt == mss_pkg::S_MS_LAST)
            begin
              nxt_s.scnt = '0;
              nxt_s.wcnt = s_ff.wcnt - 14'h0001;
            end
            else
              nxt_s.scnt = s_ff.scnt + 10'h001;
          end
        end
        ST_DONE:
        begin
          if (!trig_s || !lvl_mode)
            nxt_s.st = ST_IDLE;
        end
        default: nxt_s.st = ST_IDLE;
      endcase
    end
    nxt_s.vout = nxt_s.dir ? -32'(nxt_s.spd) : 32'(nxt_s.spd);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_ff      <= '0;
      s_ff.ctrl <= mss_pkg::CTRL_RESET;
    end
    else
      s_ff <= nxt_s;
  end

  always_comb
  begin
    prdata  = '0;
    pslverr = 1'b0;
    if (seg_area)
      prdata = mif.rdata;
    else if (addr == mss_pkg::ADDR_CTRL)
      prdata = 32'(s_ff.ctrl);
    else if (addr == mss_pkg::ADDR_STATUS)
      prdata = 32'({s_ff.seg, s_ff.intr, s_ff.st == ST_DONE, s_ff.st == ST_WAIT, active});
    else if (addr == mss_pkg::ADDR_SPEED)
      prdata = s_ff.vout;
    else if (addr == mss_pkg::ADDR_POS)
      prdata = s_ff.pos;
    else
      pslverr = psel && penable;
  end

  assign pready       = 1'b1;
  assign ref_speed_o  = s_ff.vout;
  assign ref_pos_o    = s_ff.pos;
  assign seg_active_o = active;
  assign seg_index_o  = s_ff.seg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_src_gate: assert property (s_ff.ctrl.src != mss_pkg::SRC_MULTI |=> s_ff.st == ST_IDLE)
    else $error("sequencer left idle with another position source");
  a_lvl_enable: assert property (lvl_mode && !trig_s && active |=> !active)
    else $error("segment run kept going without enable");
  a_stop_zero: assert property (lvl_mode && !trig_s && active && s_ff.ctrl.src == mss_pkg::SRC_MULTI
    |=> s_ff.spd == 16'h0000 && ref_speed_o == 32'h0000_0000)
    else $error("speed not zero right after enable loss");
  a_restart_one: assert property (s_ff.st == ST_IDLE && s_ff.intr && s_ff.ctrl.restart && trig_s && lvl_mode
    && s_ff.ctrl.src == mss_pkg::SRC_MULTI |=> s_ff.seg == 4'h0 && s_ff.st == ST_LOAD)
    else $error("restart did not begin at segment 1");
  a_sw_edge: assert property (s_ff.st == ST_IDLE && !lvl_mode && trig_s && s_ff.trig_q |=> s_ff.st == ST_IDLE)
    else $error("switching mode reacted to trigger level");
  a_sw_select: assert property (s_ff.st == ST_IDLE && !lvl_mode && trig_s && !s_ff.trig_q
    && s_ff.ctrl.src == mss_pkg::SRC_MULTI |=> s_ff.seg == $past(sel_s) && s_ff.st == ST_LOAD)
    else $error("switching run took the wrong segment");
  a_seq_nowait: assert property (s_ff.ctrl.mode == mss_pkg::MODE_SEQ && s_ff.st == ST_RUN |=> s_ff.st != ST_WAIT)
    else $error("sequence mode entered a wait");
  a_end_bound: assert property (s_ff.st == ST_RUN && lvl_mode |-> s_ff.seg <= f_end_idx(s_ff.ctrl.end_seg))
    else $error("segment beyond end segment ran");
  a_single_hold: assert property (s_ff.st == ST_DONE && trig_s && lvl_mode && s_ff.ctrl.src == mss_pkg::SRC_MULTI
    |=> s_ff.st == ST_DONE)
    else $error("single run repeated without new enable");
  a_plateau_cap: assert property (s_ff.st == ST_RUN && s_ff.ctrl.mode != mss_pkg::MODE_SEQ |-> s_ff.spd <= s_ff.tgt)
    else $error("speed above segment plateau");
  a_wait_ms: assert property (s_ff.st == ST_WAIT && s_ff.tick && !s_ff.ctrl.unit_s && s_ff.wcnt != 14'h0000
    && lvl_mode && trig_s && s_ff.ctrl.src == mss_pkg::SRC_MULTI |=> s_ff.wcnt == $past(s_ff.wcnt) - 14'h0001)
    else $error("millisecond wait did not count down");

  c_wait: cover property (s_ff.st == ST_WAIT ##1 s_ff.st == ST_LOAD);
  c_switch: cover property (!lvl_mode && s_ff.st == ST_LOAD ##[1:100] s_ff.st == ST_RUN);
  c_seq_carry: cover property (s_ff.ctrl.mode == mss_pkg::MODE_SEQ && s_ff.st == ST_LOAD && s_ff.spd != 16'h0000);
  c_resume: cover property (s_ff.st == ST_IDLE && s_ff.intr ##1 s_ff.st == ST_LOAD && s_ff.seg != 4'h0);
endmodule

// ==== verification/mss_host_model.sv ====
`timescale 1ns/1ps
module mss_host_model (
  input  wire logic       clk_i,
  output logic            trig_o,
  output logic      [3:0] sel_o
);
  // Lines live in variables of their own so that only the tasks below ever change them
  logic       trig_ff = 1'b0;
  logic [3:0] sel_ff  = 4'h0;

  assign trig_o = trig_ff;
  assign sel_o  = sel_ff;

  task automatic set_trig(input logic v);
    @(posedge clk_i);
    trig_ff <= v;
  endtask

  // Select settles well before the rising trigger, so the synchroniser never sees them change together
  task automatic fire(input logic [3:0] sel);
    @(posedge clk_i);
    sel_ff <= sel;
    repeat (6) @(posedge clk_i);
    trig_ff <= 1'b1;
  endtask
endmodule

// ==== verification/tb_multi_segment_position_sequencer.sv ====
`timescale 1ns/1ps
module tb_multi_segment_position_sequencer;
  logic        clk_i = 1'b0;
  logic        arst_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic [3:0]  sel;
  logic [31:0] ref_speed;
  logic [31:0] ref_pos;
  logic        seg_active;
  logic [3:0]  seg_index;
  int          n_mismatch;
  int          n_tests;
  int          cycles;
  logic [31:0] rd;
  logic        er;

  always #25 clk_i = ~clk_i;

  mss_sequencer #(.MS_CYCLES(20)) u_dut (
    .clk_i                   (clk_i),
    .arst_n_i                (arst_n_i),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .segment_trigger_input_i (trig),
    .segment_select_bit0_i   (sel[0]),
    .segment_select_bit1_i   (sel[1]),
    .segment_select_bit2_i   (sel[2]),
    .segment_select_bit3_i   (sel[3]),
    .ref_speed_o             (ref_speed),
    .ref_pos_o               (ref_pos),
    .seg_active_o            (seg_active),
    .seg_index_o             (seg_index)
  );

  mss_host_model u_host (
    .clk_i  (clk_i),
    .trig_o (trig),
    .sel_o  (sel)
  );

  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 50 && pready !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 50)
      n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Control word: source, mode, end segment, restart flag
  function automatic logic [31:0] ctrl(input logic [3:0] src, input logic [1:0] md, input logic [4:0] last,
                                       input logic rst);
    return {15'h0000, rst, 3'h0, last, 2'h0, md, src};
  endfunction

  task automatic seg(input int k, input logic [31:0] disp, input logic [31:0] spd, input logic [31:0] wt);
    apb(1'b1, 32'h0000_0100 + 32'(16 * k), disp);
    apb(1'b1, 32'h0000_0104 + 32'(16 * k), spd);
    apb(1'b1, 32'h0000_0108 + 32'(16 * k), 32'h0000_0000);
    apb(1'b1, 32'h0000_010C + 32'(16 * k), wt);
  endtask

  task automatic wait_act(input logic lvl);
    int i;
    for (i = 0; i < 3000 && seg_active !== lvl; i++)
      @(posedge clk_i);
    check({31'h0, seg_active}, {31'h0, lvl});
  endtask

  task automatic wait_seg(input logic [3:0] k);
    int i;
    for (i = 0; i < 3000 && seg_index !== k; i++)
      @(posedge clk_i);
    check({28'h0, seg_index}, {28'h0, k});
  endtask

  // Reads status until the waiting bit shows
  task automatic poll_wait;
    int i;
    rd = 32'h0000_0000;
    for (i = 0; i < 300 && rd[1] !== 1'b1; i++)
      apb(1'b0, 32'h0000_0004, 32'h0000_0000);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  initial
  begin
    arst_n_i <= 1'b0;
    psel     <= 1'b0;
    penable  <= 1'b0;
    pwrite   <= 1'b0;
    paddr    <= 32'h0000_0000;
    pwdata   <= 32'h0000_0000;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_0110);
    check({31'h0, er}, 32'h0000_0000);
    apb(1'b0, 32'h0000_0FF0, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, ctrl(4'h0, 2'h0, 5'h01, 1'b0));
    u_host.set_trig(1'b1);
    repeat (50) @(posedge clk_i);
    check({31'h0, seg_active}, 32'h0000_0000);
    u_host.set_trig(1'b0);
    // Switch mode: select 5 runs segment 6 only, held trigger level gives no second run
    seg(5, 32'h0000_000A, 32'h0000_0005, 32'h0000_0003);
    apb(1'b0, 32'h0000_0150, 32'h0000_0000);
    check(rd, 32'h0000_000A);
    apb(1'b1, 32'h0000_0000, ctrl(4'h2, 2'h2, 5'h01, 1'b0));
    u_host.fire(4'h5);
    wait_act(1'b1);
    repeat (12) @(posedge clk_i);
    check({28'h0, seg_index}, 32'h0000_0005);
    wait_act(1'b0);
    check(ref_pos, 32'h0000_000A);
    repeat (200) @(posedge clk_i);
    check(ref_pos, 32'h0000_000A);
    check({31'h0, seg_active}, 32'h0000_0000);
    u_host.set_trig(1'b0);
    // Single run with end segment 1: negative move, segment 2 skipped
    seg(0, 32'hFFFF_FFFA, 32'h0000_0003, 32'h0000_0001);
    seg(1, 32'h0000_0064, 32'h0000_0005, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, ctrl(4'h2, 2'h0, 5'h01, 1'b0));
    u_host.fire(4'h0);
    wait_act(1'b1);
    for (int i = 0; i < 300 && ref_speed === 32'h0000_0000; i++)
      @(posedge clk_i);
    check(ref_speed, 32'hFFFF_FFFD);
    wait_act(1'b0);
    repeat (200) @(posedge clk_i);
    check(ref_pos, 32'h0000_0004);
    apb(1'b0, 32'h0000_000C, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    u_host.set_trig(1'b0);
    // Sequence run over two segments: total equals the sum of both
    seg(1, 32'h0000_0004, 32'h0000_0002, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, ctrl(4'h2, 2'h3, 5'h02, 1'b0));
    u_host.set_trig(1'b1);
    wait_act(1'b1);
    wait_act(1'b0);
    check(ref_pos, 32'h0000_0002);
    u_host.set_trig(1'b0);
    // Interruption in segment 1, then resume at segment 2 or restart at segment 1
    seg(0, 32'h0000_0028, 32'h0000_0002, 32'h0000_0000);
    seg(1, 32'h0000_0028, 32'h0000_0002, 32'h0000_0000);
    for (int r = 0; r < 2; r++)
    begin
      apb(1'b1, 32'h0000_0000, ctrl(4'h0, 2'h0, 5'h02, 1'(r)));
      apb(1'b1, 32'h0000_0000, ctrl(4'h2, 2'h0, 5'h02, 1'(r)));
      u_host.set_trig(1'b1);
      wait_act(1'b1);
      repeat (80) @(posedge clk_i);
      u_host.set_trig(1'b0);
      repeat (8) @(posedge clk_i);
      check(ref_speed, 32'h0000_0000);
      check({31'h0, seg_active}, 32'h0000_0000);
      u_host.set_trig(1'b1);
      wait_act(1'b1);
      repeat (40) @(posedge clk_i);
      check({28'h0, seg_index}, (r == 1) ? 32'h0000_0000 : 32'h0000_0001);
      u_host.set_trig(1'b0);
      wait_act(1'b0);
    end
    // Cycle run in ms: segment 1 waits, segment 2 follows, then segment 1 again
    seg(0, 32'h0000_0004, 32'h0000_0004, 32'h0000_0002);
    seg(1, 32'h0000_0004, 32'h0000_0004, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, ctrl(4'h0, 2'h1, 5'h02, 1'b0));
    apb(1'b1, 32'h0000_0000, ctrl(4'h2, 2'h1, 5'h02, 1'b0));
    u_host.set_trig(1'b1);
    poll_wait();
    check(rd, 32'h0000_0003);
    apb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wait_seg(4'h1);
    wait_seg(4'h0);
    check({31'h0, seg_active}, 32'h0000_0001);
    // Same wait counted in seconds must outlast its millisecond length many times over
    apb(1'b1, 32'h0000_0000, ctrl(4'h2, 2'h1, 5'h02, 1'b0) | 32'h0002_0000);
    poll_wait();
    check(rd, 32'h0000_0003);
    repeat (200) @(posedge clk_i);
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    // Reset in mid-run: outputs clear, control word back to its reset value
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    check({31'h0, seg_active}, 32'h0000_0000);
    check(ref_pos, 32'h0000_0000);
    check(ref_speed, 32'h0000_0000);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_0110);
    u_host.set_trig(1'b0);
    conclude();
  end
endmodule
